/* inc/drive_start_stop_pkg.sv */
// constants shared by the start/stop decoder, its checker and its bench
package drive_start_stop_pkg;

  // ***************************************************************
  // register map (byte addresses on the plain register port)
  // ***************************************************************
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [7:0] CFG_OFFSET = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;

  // ***************************************************************
  // configuration register fields
  // ***************************************************************
  localparam int SRC_W = 2;
  localparam int REF_W = 4;
  localparam int MODE_W = 4;
  localparam int CFG_LOC_SRC_LSB = 0;
  localparam int CFG_REM_SRC_LSB = 2;
  localparam int CFG_LOC_REF_LSB = 4;
  localparam int CFG_REM_REF_LSB = 8;
  localparam int CFG_MODE_LSB = 12;
  localparam int CFG_GROUP_BIT = 16;
  localparam logic [31:0] CFG_RESET = 32'h0000_0000;

  // ***************************************************************
  // status register fields
  // ***************************************************************
  localparam int ST_PLACE_BIT = 0;
  localparam int ST_RUN_BIT = 1;
  localparam int ST_REV_BIT = 2;
  localparam int ST_ARMED_BIT = 3;
  localparam int ST_MODE_LSB = 4;
  localparam int ST_SRC_LSB = 8;
  localparam int ST_REF_LSB = 10;
  localparam int ST_REF_UP_BIT = 14;

  // ***************************************************************
  // control sources and reference sources
  // ***************************************************************
  localparam logic [1:0] SRC_TERMINALS = 2'h0;
  localparam logic [1:0] SRC_KEYPAD = 2'h1;
  localparam logic [1:0] SRC_FIELDBUS = 2'h2;
  localparam logic [3:0] REF_VOLTAGE = 4'h0;
  localparam logic [3:0] REF_CURRENT = 4'h1;
  localparam logic [3:0] REF_KEYPAD = 4'h2;
  localparam logic [3:0] REF_FIELDBUS = 4'h3;
  localparam logic [3:0] REF_MOTOR_POT = 4'h4;

  // ***************************************************************
  // start/stop logic modes (group a: level/edge set, b: pot set)
  // ***************************************************************
  localparam logic [3:0] MODE_FWD_REV = 4'h0;
  localparam logic [3:0] MODE_START_DIR = 4'h1;
  localparam logic [3:0] MODE_PULSE = 4'h3;
  localparam logic [3:0] MODE_POT = 4'h4;
  localparam logic [3:0] MODE_A_EDGE_FWD_REV = 4'h4;
  localparam logic [3:0] MODE_A_EDGE_START_DIR = 4'h5;
  localparam logic [3:0] MODE_A_EDGE_ENABLE = 4'h6;
  localparam logic [3:0] MODE_B_EDGE_FWD_REV = 4'h5;
  localparam logic [3:0] MODE_B_EDGE_START_DIR = 4'h6;
  localparam logic [3:0] MODE_B_EDGE_ENABLE = 4'h7;
  localparam logic [3:0] MODE_B_EDGE_POT = 4'h8;

  typedef enum logic [1:0] {
    ST_STOP,
    ST_FWD,
    ST_REV
  } run_state_type;

endpackage

/* inc/contact_if.sv */
// conditioned contact levels and edges passed from conditioner to decoder
`timescale 1ns/1ps
interface contact_if;
  logic a_level;
  logic a_rise;
  logic b_level;
  logic b_fall;
  logic c_level;
  logic button_rise;

  modport producer (
    output a_level,
    output a_rise,
    output b_level,
    output b_fall,
    output c_level,
    output button_rise
  );
  modport consumer (
    input a_level,
    input a_rise,
    input b_level,
    input b_fall,
    input c_level,
    input button_rise
  );
endinterface

/* verilog/contact_conditioner.sv */
// two-stage synchronisers and edge detection for the contact inputs
`timescale 1ns/1ps
module contact_conditioner (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_resetn,
  // raw contacts: a, b, c, place toggle button
  input wire logic [3:0] i_raw,
  // conditioned view
  contact_if.producer o_cond
);

  logic [3:0] meta_ff;
  logic [3:0] sync_ff;
  logic [3:0] prev_ff;
  logic [3:0] nxt_meta;
  logic [3:0] nxt_sync;
  logic [3:0] nxt_prev;

  // meta stage feeds only the sync stage; prev holds the last clean sample
  always_comb begin
    nxt_meta = i_raw;
    nxt_sync = meta_ff;
    nxt_prev = sync_ff;
  end

  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      meta_ff <= 4'h0;
      sync_ff <= 4'h0;
      prev_ff <= 4'h0;
    end else begin
      meta_ff <= nxt_meta;
      sync_ff <= nxt_sync;
      prev_ff <= nxt_prev;
    end
  end

  // edges compare the current clean sample with the previous one
  assign o_cond.a_level = sync_ff[0];
  assign o_cond.a_rise = sync_ff[0] & ~prev_ff[0];
  assign o_cond.b_level = sync_ff[1];
  assign o_cond.b_fall = ~sync_ff[1] & prev_ff[1];
  assign o_cond.c_level = sync_ff[2];
  assign o_cond.button_rise = sync_ff[3] & ~prev_ff[3];

endmodule

/* verilog/drive_start_stop_decoder.sv */
// run and direction command decoder for a motor drive control place
//
// Strobed register access and the address map were chosen for this implementation.
`timescale 1ns/1ps
module drive_start_stop_decoder (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_resetn,
  // contacts and keypad button
  input wire logic i_start_input_a,
  input wire logic i_start_input_b,
  input wire logic i_aux_input_c,
  input wire logic i_place_toggle_button,
  // drive events from same-clock logic
  input wire logic i_power_restored,
  input wire logic i_fault_reset,
  input wire logic i_run_enable,
  // run command from a keypad or fieldbus source
  input wire logic i_alt_run,
  input wire logic i_alt_reverse,
  // register port
  input wire logic [drive_start_stop_pkg::ADDR_W-1:0] i_addr,
  input wire logic [drive_start_stop_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [drive_start_stop_pkg::DATA_W-1:0] o_rdata,
  // drive command
  output logic o_run,
  output logic o_reverse,
  output logic o_ref_up,
  output logic o_remote,
  output logic [drive_start_stop_pkg::SRC_W-1:0] o_active_source,
  output logic [drive_start_stop_pkg::REF_W-1:0] o_active_reference
);

  // ***************************************************************
  // helpers
  // ***************************************************************

  // true for the modes that need the start contact seen open first
  function automatic logic edge_mode(input logic [3:0] mode,
                                     input logic grp);
    if (!grp) begin
      edge_mode = (mode == drive_start_stop_pkg::MODE_A_EDGE_FWD_REV) ||
                  (mode == drive_start_stop_pkg::MODE_A_EDGE_START_DIR) ||
                  (mode == drive_start_stop_pkg::MODE_A_EDGE_ENABLE);
    end else begin
      edge_mode = (mode == drive_start_stop_pkg::MODE_B_EDGE_FWD_REV) ||
                  (mode == drive_start_stop_pkg::MODE_B_EDGE_START_DIR) ||
                  (mode == drive_start_stop_pkg::MODE_B_EDGE_ENABLE) ||
                  (mode == drive_start_stop_pkg::MODE_B_EDGE_POT);
    end
  endfunction

  // pick a field out of the configuration word
  function automatic logic [3:0] cfg_field(input logic [31:0] cfg,
                                           input int lsb,
                                           input int width);
    logic [31:0] shifted;
    shifted = cfg >> lsb;
    cfg_field = shifted[3:0] & ((4'h1 << width) - 4'h1);
  endfunction

  // ***************************************************************
  // contact conditioning
  // ***************************************************************
  contact_if cond ();

  contact_conditioner u_cond (
    .i_mclk(i_mclk),
    .i_resetn(i_resetn),
    .i_raw({i_place_toggle_button, i_aux_input_c, i_start_input_b,
            i_start_input_a}),
    .o_cond(cond)
  );

  // ***************************************************************
  // registers
  // ***************************************************************
  logic [31:0] cfg_ff;
  logic [31:0] nxt_cfg;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic [31:0] status;
  logic place_ff;
  logic nxt_place;
  logic armed_ff;
  logic nxt_armed;
  drive_start_stop_pkg::run_state_type state_ff;
  drive_start_stop_pkg::run_state_type nxt_state;
  logic run_ff;
  logic rev_ff;
  logic ref_up_ff;
  logic remote_ff;
  logic [1:0] src_ff;
  logic [3:0] ref_ff;
  logic nxt_ref_up;
  logic [1:0] nxt_src;
  logic [3:0] nxt_ref;

  // configuration fields
  logic [1:0] loc_src;
  logic [1:0] rem_src;
  logic [3:0] loc_ref;
  logic [3:0] rem_ref;
  logic [3:0] set_mode;
  logic [3:0] eff_mode;
  logic grp;

  assign loc_src = drive_start_stop_pkg::SRC_W'(
      cfg_field(cfg_ff, drive_start_stop_pkg::CFG_LOC_SRC_LSB,
                drive_start_stop_pkg::SRC_W));
  assign rem_src = drive_start_stop_pkg::SRC_W'(
      cfg_field(cfg_ff, drive_start_stop_pkg::CFG_REM_SRC_LSB,
                drive_start_stop_pkg::SRC_W));
  assign loc_ref = cfg_field(cfg_ff, drive_start_stop_pkg::CFG_LOC_REF_LSB,
                             drive_start_stop_pkg::REF_W);
  assign rem_ref = cfg_field(cfg_ff, drive_start_stop_pkg::CFG_REM_REF_LSB,
                             drive_start_stop_pkg::REF_W);
  assign set_mode = cfg_field(cfg_ff, drive_start_stop_pkg::CFG_MODE_LSB,
                              drive_start_stop_pkg::MODE_W);
  assign grp = cfg_ff[drive_start_stop_pkg::CFG_GROUP_BIT];

  // pot-type remote reference overrides the chosen mode in group b only
  always_comb begin
    eff_mode = set_mode;
    if (grp && ((rem_ref == drive_start_stop_pkg::REF_FIELDBUS) ||
                (rem_ref == drive_start_stop_pkg::REF_MOTOR_POT))) begin
      eff_mode = drive_start_stop_pkg::MODE_POT;
    end
  end

  // ***************************************************************
  // register port
  // ***************************************************************
  always_comb begin
    status = 32'h0000_0000;
    status[drive_start_stop_pkg::ST_PLACE_BIT] = place_ff;
    status[drive_start_stop_pkg::ST_RUN_BIT] = run_ff;
    status[drive_start_stop_pkg::ST_REV_BIT] = rev_ff;
    status[drive_start_stop_pkg::ST_ARMED_BIT] = armed_ff;
    status[drive_start_stop_pkg::ST_MODE_LSB +: 4] = eff_mode;
    status[drive_start_stop_pkg::ST_SRC_LSB +: 2] = src_ff;
    status[drive_start_stop_pkg::ST_REF_LSB +: 4] = ref_ff;
    status[drive_start_stop_pkg::ST_REF_UP_BIT] = ref_up_ff;
  end

  // unmapped reads return zero, unmapped writes are dropped
  always_comb begin
    nxt_cfg = cfg_ff;
    nxt_rdata = 32'h0000_0000;
    if (i_wr && (i_addr == drive_start_stop_pkg::CFG_OFFSET)) begin
      nxt_cfg = i_wdata;
    end
    if (i_rd) begin
      if (i_addr == drive_start_stop_pkg::CFG_OFFSET) begin
        nxt_rdata = cfg_ff;
      end else if (i_addr == drive_start_stop_pkg::STATUS_OFFSET) begin
        nxt_rdata = status;
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      cfg_ff <= drive_start_stop_pkg::CFG_RESET;
      rdata_ff <= 32'h0000_0000;
    end else begin
      cfg_ff <= nxt_cfg;
      rdata_ff <= nxt_rdata;
    end
  end

  // ***************************************************************
  // control place and arming
  // ***************************************************************
  logic place_change;
  logic disarm;

  assign place_change = cond.button_rise;
  // every event after which an unintended start must be excluded
  assign disarm = place_change | i_power_restored | i_fault_reset |
                  ~i_run_enable;

  // disarm wins over arming so a contact held closed stays refused
  always_comb begin
    nxt_place = place_ff;
    nxt_armed = armed_ff;
    if (place_change) begin
      nxt_place = ~place_ff;
    end
    if (disarm) begin
      nxt_armed = 1'b0;
    end else if (!cond.a_level) begin
      nxt_armed = 1'b1;
    end
  end

  // reset clears the arm, but the synchroniser reads open after reset, so the arm sets again on the first clock
  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      place_ff <= 1'b0;
      armed_ff <= 1'b0;
    end else begin
      place_ff <= nxt_place;
      armed_ff <= nxt_armed;
    end
  end

  // ***************************************************************
  // start/stop decoding
  // ***************************************************************
  logic [1:0] act_src;
  logic [3:0] act_ref;
  logic running;
  logic start_ok;
  logic is_edge;

  assign act_src = place_ff ? rem_src : loc_src;
  assign act_ref = place_ff ? rem_ref : loc_ref;
  assign running = (state_ff != drive_start_stop_pkg::ST_STOP);
  assign is_edge = edge_mode(eff_mode, grp);
  // level modes start freely; edge modes need the arm, kept while running
  assign start_ok = !is_edge || armed_ff || running;

  always_comb begin
    nxt_state = drive_start_stop_pkg::ST_STOP;
    nxt_ref_up = 1'b0;
    if (act_src != drive_start_stop_pkg::SRC_TERMINALS) begin
      // keypad or fieldbus command bypasses the contacts
      if (i_alt_run) begin
        nxt_state = i_alt_reverse ? drive_start_stop_pkg::ST_REV :
                                    drive_start_stop_pkg::ST_FWD;
      end
    end else if (!grp && (eff_mode == drive_start_stop_pkg::MODE_A_EDGE_ENABLE)
                 || grp && (eff_mode == drive_start_stop_pkg::MODE_B_EDGE_ENABLE))
    begin
      if (cond.a_level && cond.b_level && start_ok) begin
        nxt_state = drive_start_stop_pkg::ST_FWD;
      end
    end else if (eff_mode == drive_start_stop_pkg::MODE_FWD_REV ||
                 (!grp && eff_mode == drive_start_stop_pkg::MODE_A_EDGE_FWD_REV) ||
                 (grp && eff_mode == drive_start_stop_pkg::MODE_B_EDGE_FWD_REV))
    begin
      if (cond.a_level && cond.b_level) begin
        if (running) begin
          nxt_state = state_ff;
        end else if (start_ok) begin
          nxt_state = drive_start_stop_pkg::ST_FWD;
        end
      end else if (cond.a_level && start_ok) begin
        nxt_state = drive_start_stop_pkg::ST_FWD;
      end else if (cond.b_level && (start_ok || cond.a_level == 1'b0 &&
                                    running)) begin
        nxt_state = drive_start_stop_pkg::ST_REV;
      end
    end else if (eff_mode == drive_start_stop_pkg::MODE_START_DIR ||
                 (!grp && eff_mode == drive_start_stop_pkg::MODE_A_EDGE_START_DIR) ||
                 (grp && eff_mode == drive_start_stop_pkg::MODE_B_EDGE_START_DIR))
    begin
      if (cond.a_level && start_ok) begin
        nxt_state = cond.b_level ? drive_start_stop_pkg::ST_REV :
                                   drive_start_stop_pkg::ST_FWD;
      end
    end else if (eff_mode == drive_start_stop_pkg::MODE_PULSE) begin
      // stop pulse wins over a start pulse in the same cycle
      if (cond.b_fall || !cond.b_level) begin
        nxt_state = drive_start_stop_pkg::ST_STOP;
      end else if (cond.a_rise || running) begin
        nxt_state = cond.c_level ? drive_start_stop_pkg::ST_REV :
                                   drive_start_stop_pkg::ST_FWD;
      end
    end else if (grp && (eff_mode == drive_start_stop_pkg::MODE_POT ||
                         eff_mode == drive_start_stop_pkg::MODE_B_EDGE_POT))
    begin
      if (cond.a_level && start_ok) begin
        nxt_state = drive_start_stop_pkg::ST_FWD;
      end
      nxt_ref_up = cond.b_level;
    end
    // run enable low stops the drive whatever the mode
    if (!i_run_enable) begin
      nxt_state = drive_start_stop_pkg::ST_STOP;
      nxt_ref_up = 1'b0;
    end
    nxt_src = act_src;
    nxt_ref = act_ref;
  end

  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      state_ff <= drive_start_stop_pkg::ST_STOP;
      run_ff <= 1'b0;
      rev_ff <= 1'b0;
      ref_up_ff <= 1'b0;
      remote_ff <= 1'b0;
      src_ff <= drive_start_stop_pkg::SRC_TERMINALS;
      ref_ff <= drive_start_stop_pkg::REF_VOLTAGE;
    end else begin
      state_ff <= nxt_state;
      run_ff <= (nxt_state != drive_start_stop_pkg::ST_STOP);
      rev_ff <= (nxt_state == drive_start_stop_pkg::ST_REV);
      ref_up_ff <= nxt_ref_up;
      remote_ff <= nxt_place;
      src_ff <= nxt_src;
      ref_ff <= nxt_ref;
    end
  end

  // ***************************************************************
  // outputs, each straight from a flip-flop
  // ***************************************************************
  assign o_rdata = rdata_ff;
  assign o_run = run_ff;
  assign o_reverse = rev_ff;
  assign o_ref_up = ref_up_ff;
  assign o_remote = remote_ff;
  assign o_active_source = src_ff;
  assign o_active_reference = ref_ff;

endmodule

/* sim/drive_start_stop_chk.sv */
// port assertions for the start/stop decoder
`timescale 1ns/1ps
module drive_start_stop_chk (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_resetn,
  // inputs watched
  input wire logic i_start_input_a,
  input wire logic i_start_input_b,
  input wire logic i_place_toggle_button,
  input wire logic i_run_enable,
  input wire logic [drive_start_stop_pkg::ADDR_W-1:0] i_addr,
  input wire logic [drive_start_stop_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  // outputs watched
  input wire logic [drive_start_stop_pkg::DATA_W-1:0] o_rdata,
  input wire logic o_run,
  input wire logic o_reverse,
  input wire logic o_remote,
  input wire logic [drive_start_stop_pkg::SRC_W-1:0] o_active_source,
  input wire logic [drive_start_stop_pkg::REF_W-1:0] o_active_reference
);
  logic [31:0] cfg_ff;
  logic [31:0] nxt_cfg;
  logic [3:0] mode;
  logic loc_term;

  // shadow of the configuration word, so modes can be judged here
  always_comb begin
    nxt_cfg = cfg_ff;
    if (!i_resetn) begin
      nxt_cfg = drive_start_stop_pkg::CFG_RESET;
    end else if (i_wr && i_addr == drive_start_stop_pkg::CFG_OFFSET) begin
      nxt_cfg = i_wdata;
    end
  end
  always_ff @(posedge i_mclk) begin
    cfg_ff <= nxt_cfg;
  end
  // local place on terminals, group a, drive enabled
  assign mode = cfg_ff[15:12];
  assign loc_term = !o_remote && cfg_ff[1:0] == 2'h0 && !cfg_ff[16] &&
                    i_run_enable;

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_resetn);

  sequence s_btn_rise;
    !i_place_toggle_button ##1 i_place_toggle_button;
  endsequence
  // settle window: no config change and no place change
  sequence s_quiet;
    ($stable(cfg_ff) && $stable(o_remote)) [*4];
  endsequence

  a_toggle_place: assert property (
    s_btn_rise |-> ##[1:4] (o_remote != $past(o_remote)))
    else $error("place did not toggle");
  a_source_shown: assert property (
    s_quiet |-> o_active_source == (o_remote ? cfg_ff[3:2] : cfg_ff[1:0]))
    else $error("active source wrong");
  a_ref_shown: assert property (
    s_quiet |-> o_active_reference ==
      (o_remote ? cfg_ff[11:8] : cfg_ff[7:4]))
    else $error("active reference wrong");
  a_mode0_idle: assert property (
    (loc_term && mode == 4'h0 && !i_start_input_a && !i_start_input_b)
      [*5] |-> !o_run)
    else $error("runs with both starts open");
  a_mode1_rev: assert property (
    (loc_term && mode == 4'h1 && i_start_input_a && i_start_input_b)
      [*5] |-> o_run && o_reverse)
    else $error("start plus direction wrong");
  a_rev_with_run: assert property (
    o_reverse |-> o_run)
    else $error("reverse while stopped");
  a_enable_stop: assert property (
    !i_run_enable |-> ##[1:3] !o_run)
    else $error("run enable low did not stop");
  a_rdata_idle: assert property (
    !$past(i_rd) |-> o_rdata == 32'h0000_0000)
    else $error("read data outside its cycle");
  a_unmapped_zero: assert property (
    i_rd && i_addr != 8'h00 && i_addr != 8'h04 |=> o_rdata == 32'h0)
    else $error("unmapped read not zero");
  a_status_state: assert property (
    i_rd && i_addr == 8'h04 |=> o_rdata[0] == $past(o_remote) &&
      o_rdata[1] == $past(o_run))
    else $error("status does not match outputs");
endmodule

bind drive_start_stop_decoder drive_start_stop_chk u_drive_start_stop_chk (
  .i_mclk, .i_resetn, .i_start_input_a, .i_start_input_b,
  .i_place_toggle_button, .i_run_enable, .i_addr, .i_wdata, .i_wr, .i_rd,
  .o_rdata, .o_run, .o_reverse, .o_remote, .o_active_source,
  .o_active_reference);

/* sim/contact_model.sv */
// behavioural switch contacts and keypad place button
`timescale 1ns/1ps
module contact_model (
  // clock
  input wire logic i_mclk,
  // contact levels, high = closed
  output logic o_a,
  output logic o_b,
  output logic o_c,
  output logic o_button
);
  // contacts open and button released at power-up
  initial begin
    o_a = 1'b0;
    o_b = 1'b0;
    o_c = 1'b0;
    o_button = 1'b0;
  end
  // contacts move just after an edge; real contacts are asynchronous
  task automatic set_contacts(input logic a, input logic b, input logic c);
    @(posedge i_mclk);
    o_a <= a;
    o_b <= b;
    o_c <= c;
  endtask
  // a press held long enough for the synchroniser to see both edges
  task automatic press;
    @(posedge i_mclk);
    o_button <= 1'b1;
    repeat (4) @(posedge i_mclk);
    o_button <= 1'b0;
    repeat (4) @(posedge i_mclk);
  endtask
endmodule

/* sim/drive_start_stop_decoder_bench.sv */
// self-checking bench for the start/stop decoder
`timescale 1ns/1ps
module drive_start_stop_decoder_bench;
  logic i_mclk = 1'b0;
  logic i_resetn = 1'b0;
  logic i_power_restored = 1'b0;
  logic i_fault_reset = 1'b0;
  logic i_run_enable = 1'b1;
  logic i_alt_run = 1'b0;
  logic i_alt_reverse = 1'b0;
  logic [7:0] i_addr = 8'h00;
  logic [31:0] i_wdata = 32'h0;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [31:0] o_rdata;
  logic o_run, o_reverse, o_ref_up, o_remote;
  logic [1:0] o_active_source;
  logic [3:0] o_active_reference;
  logic pin_a, pin_b, pin_c, pin_btn;
  logic [31:0] v, w;
  logic [1:0] ls, rs;
  logic [3:0] lr, rr;
  int fails = 0;
  int num_checks = 0;
  int seed = 32'hB072;

  // 20 MHz clock
  always #25 i_mclk = ~i_mclk;

  drive_start_stop_decoder u_drive_start_stop_decoder (
    .i_mclk(i_mclk), .i_resetn(i_resetn), .i_start_input_a(pin_a),
    .i_start_input_b(pin_b), .i_aux_input_c(pin_c),
    .i_place_toggle_button(pin_btn), .i_power_restored(i_power_restored),
    .i_fault_reset(i_fault_reset), .i_run_enable(i_run_enable),
    .i_alt_run(i_alt_run), .i_alt_reverse(i_alt_reverse), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .o_run(o_run), .o_reverse(o_reverse), .o_ref_up(o_ref_up),
    .o_remote(o_remote), .o_active_source(o_active_source),
    .o_active_reference(o_active_reference));
  contact_model u_contact_model (.i_mclk(i_mclk), .o_a(pin_a), .o_b(pin_b),
    .o_c(pin_c), .o_button(pin_btn));

  // configuration word from its fields
  function automatic logic [31:0] cfg(input logic [1:0] s0, s1,
    input logic [3:0] r0, r1, md, input logic grp);
    cfg = {15'h0, grp, md, r1, r0, s1, s0};
  endfunction
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_mclk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_mclk);
    i_wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge i_mclk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t value %h expected %h", $time, got, exp);
    end
  endtask
  // sync plus register latency is a few cycles; wait beyond it
  task automatic con(input logic a, input logic b, input logic c);
    u_contact_model.set_contacts(a, b, c);
    repeat (6) @(posedge i_mclk);
    #1;
  endtask
  task automatic chk_cmd(input logic run, input logic rev);
    num_checks++;
    if ({o_run, o_reverse} !== {run, rev}) begin
      fails++;
      $display("BAD %0t run/rev %b%b expected %b%b", $time, o_run,
        o_reverse, run, rev);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // watchdog well beyond the sequence length
  initial begin
    repeat (20000) @(posedge i_mclk);
    fails++;
    $display("BAD %0t watchdog expired", $time);
    stop_test;
  end

  initial begin
    repeat (2) @(posedge i_mclk);
    i_resetn <= 1'b1;
    // reset values; armed bit may already be set, so it is masked
    rd_reg(drive_start_stop_pkg::CFG_OFFSET, v);
    chk_reg(v, drive_start_stop_pkg::CFG_RESET);
    rd_reg(drive_start_stop_pkg::STATUS_OFFSET, v);
    chk_reg(v & 32'hFFFF_FFF7, 32'h0);
    // refused writes: unmapped and read-only
    wr_reg(8'h08, 32'hFFFF_FFFF);
    rd_reg(8'h08, v);
    chk_reg(v, 32'h0);
    wr_reg(drive_start_stop_pkg::STATUS_OFFSET, 32'hFFFF_FFFF);
    rd_reg(drive_start_stop_pkg::STATUS_OFFSET, v);
    chk_reg(v & 32'hFFFF_FFF7, 32'h0);
    // random per-place source and reference, both places
    for (int i = 0; i < 6; i++) begin
      ls = 2'($unsigned($random(seed)) % 3);
      rs = 2'($unsigned($random(seed)) % 3);
      lr = 4'($unsigned($random(seed)) % 5);
      rr = 4'($unsigned($random(seed)) % 5);
      w = cfg(ls, rs, lr, rr, 4'h1, 1'b0);
      wr_reg(drive_start_stop_pkg::CFG_OFFSET, w);
      rd_reg(drive_start_stop_pkg::CFG_OFFSET, v);
      chk_reg(v, w);
      con(1'b0, 1'b0, 1'b0);
      chk_reg(32'({o_remote, o_active_source, o_active_reference}),
        32'({1'b0, ls, lr}));
      u_contact_model.press;
      con(1'b0, 1'b0, 1'b0);
      chk_reg(32'({o_remote, o_active_source, o_active_reference}),
        32'({1'b1, rs, rr}));
      u_contact_model.press;
    end
    // keypad source takes its own run command and ignores contacts
    wr_reg(8'h00, cfg(2'h1, 2'h0, 4'h2, 4'h0, 4'h0, 1'b0));
    i_alt_run <= 1'b1;
    i_alt_reverse <= 1'b1;
    con(1'b1, 1'b0, 1'b0);
    chk_cmd(1'b1, 1'b1);
    i_alt_run <= 1'b0;
    i_alt_reverse <= 1'b0;
    // level forward/reverse on terminals
    wr_reg(8'h00, cfg(2'h0, 2'h0, 4'h0, 4'h0, 4'h0, 1'b0));
    con(1'b1, 1'b0, 1'b0);
    chk_cmd(1'b1, 1'b0);
    con(1'b1, 1'b1, 1'b0);
    chk_cmd(1'b1, 1'b0);
    con(1'b0, 1'b1, 1'b0);
    chk_cmd(1'b1, 1'b1);
    con(1'b1, 1'b1, 1'b0);
    chk_cmd(1'b1, 1'b1);
    con(1'b0, 1'b0, 1'b0);
    chk_cmd(1'b0, 1'b0);
    con(1'b1, 1'b1, 1'b0);
    chk_cmd(1'b1, 1'b0);
    // start plus direction, every contact pair
    wr_reg(8'h00, cfg(2'h0, 2'h0, 4'h0, 4'h0, 4'h1, 1'b0));
    for (int k = 0; k < 4; k++) begin
      con(k[1], k[0], 1'b0);
      chk_cmd(k[1], k[1] & k[0]);
    end
    // three-wire pulse control, direction from contact c
    con(1'b0, 1'b1, 1'b0);
    wr_reg(8'h00, cfg(2'h0, 2'h0, 4'h0, 4'h0, 4'h3, 1'b0));
    con(1'b1, 1'b1, 1'b0);
    con(1'b0, 1'b1, 1'b0);
    chk_cmd(1'b1, 1'b0);
    con(1'b0, 1'b1, 1'b1);
    chk_cmd(1'b1, 1'b1);
    con(1'b0, 1'b0, 1'b1);
    chk_cmd(1'b0, 1'b0);
    // edge-required forward/reverse: disarm with the contact held
    con(1'b0, 1'b0, 1'b0);
    wr_reg(8'h00, cfg(2'h0, 2'h0, 4'h0, 4'h0, 4'h4, 1'b0));
    con(1'b1, 1'b0, 1'b0);
    chk_cmd(1'b1, 1'b0);
    // power restoration disarms even while the drive keeps running
    @(posedge i_mclk);
    i_power_restored <= 1'b1;
    @(posedge i_mclk);
    i_power_restored <= 1'b0;
    rd_reg(drive_start_stop_pkg::STATUS_OFFSET, v);
    chk_reg(32'(v[3:1]), 32'h1);
    @(posedge i_mclk);
    i_run_enable <= 1'b0;
    @(posedge i_mclk);
    i_run_enable <= 1'b1;
    i_fault_reset <= 1'b1;
    @(posedge i_mclk);
    i_fault_reset <= 1'b0;
    con(1'b1, 1'b0, 1'b0);
    chk_cmd(1'b0, 1'b0);
    con(1'b0, 1'b0, 1'b0);
    con(1'b1, 1'b0, 1'b0);
    chk_cmd(1'b1, 1'b0);
    // start-enable mode in both groups (codes 6 and 7)
    for (int g = 0; g < 2; g++) begin
      con(1'b0, 1'b0, 1'b0);
      wr_reg(8'h00, cfg(2'h0, 2'h0, 4'h0, 4'h0, 4'(6 + g), g[0]));
      con(1'b1, 1'b0, 1'b0);
      chk_cmd(1'b0, 1'b0);
      con(1'b1, 1'b1, 1'b0);
      chk_cmd(1'b1, 1'b0);
      con(1'b1, 1'b0, 1'b0);
      chk_cmd(1'b0, 1'b0);
    end
    // motor potentiometer mode, then forcing by remote reference
    con(1'b0, 1'b0, 1'b0);
    wr_reg(8'h00, cfg(2'h0, 2'h0, 4'h0, 4'h0, 4'h4, 1'b1));
    con(1'b1, 1'b1, 1'b0);
    chk_reg(32'({o_run, o_reverse, o_ref_up}), 32'h5);
    con(1'b0, 1'b0, 1'b0);
    wr_reg(8'h00, cfg(2'h0, 2'h0, 4'h0, 4'h3, 4'h0, 1'b1));
    u_contact_model.press;
    con(1'b0, 1'b1, 1'b0);
    chk_reg(32'({o_run, o_reverse, o_ref_up}), 32'h1);
    rd_reg(drive_start_stop_pkg::STATUS_OFFSET, v);
    chk_reg(32'(v[7:4]), 32'h4);
    con(1'b0, 1'b0, 1'b0);
    stop_test;
  end
endmodule
